/* core/tla_alert_top.sv */
// temperature limit comparison, status flags, alert and critical outputs
//
// Contract
// - after each conversion compare readings with limits, flag violations
// - local checks high only; remote checks high, low and critical
// - mask clear: alert low while any flag except busy and fault is set; in comparator mode alert follows cond_reg, not the flags
// - mask bit zero enables alert, one suppresses it in all modes
// - critical output low while remote temperature exceeds critical limit
// - critical hysteresis and lookup hysteresis live in separate registers
// - unsigned select chooses format for remote high and critical compares
// - comparator mode releases alert once the condition disappears
// - comparator bit low at reset: alert behaves as latched interrupt
// - interrupt mode status read sets mask if a qualifying flag set
// - flags clear only on status read, reassert next conversion
// - interrupt mode status read clears status and releases alert
// - standby bit stops continuous conversions
// - configuration bit decides if fan pwm halts in standby
// - local values 8 bits; remote values 11 bits left justified
// - digital filter widens remote reading from 11 to 13 bits
// - signed offset pair is added to remote reading before reporting
// - answer alert query only with alert config low; release and mask
// - critical clears at or below limit minus hysteresis, whole degrees
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module tla_alert_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tla_pkg::tla_conv_s conv,
  input wire logic conv_busy,
  input wire logic diode_fault,
  input wire logic alert_response_query,
  output logic alert_n,
  output logic critical_temp_out_n,
  output logic conv_enable,
  output logic pwm_halt,
  output logic ara_ack
);

  logic [7:0] config_reg;
  logic [7:0] enh_config_reg;
  logic [7:0] filter_mode_reg;
  logic [7:0] local_high_limit;
  logic [15:0] remote_high_limit;
  logic [15:0] remote_low_limit;
  logic [15:0] remote_critical_limit;
  logic [7:0] crit_hyst_reg;
  logic [7:0] lut_hyst_reg;
  logic [15:0] remote_offset_reg;
  logic [7:0] local_temp_reading;
  logic [15:0] remote_temp_reading;
  logic [tla_pkg::NUM_FLAGS-1:0] flag_reg;
  logic [tla_pkg::NUM_FLAGS-1:0] cond_reg;
  logic [tla_pkg::NUM_FLAGS-1:0] viol;
  logic crit_active_reg;
  logic crit_active_next;
  logic [15:0] remote_new;
  logic wr_done;
  logic rd_done;
  logic status_rd;
  logic irq_mode;
  logic qual_any;
  logic hw_mask_set;
  logic ara_hit;
  logic alert_next;

  wire logic mask = config_reg[tla_pkg::CFG_MASK_BIT];
  wire logic unsigned_format_select = enh_config_reg[tla_pkg::ENH_USF_BIT];
  wire logic filter_en = filter_mode_reg[tla_pkg::FM_FILTER_BIT];
  wire logic comp_mode = filter_mode_reg[tla_pkg::FM_COMP_BIT];
  wire logic alert_cfg = filter_mode_reg[tla_pkg::FM_ALERTCFG_BIT];

  // widen a left justified remote value to 17 bits in the chosen format
  function automatic logic signed [16:0] fmt_ext(input logic [15:0] v,
                                                 input logic uns);
    fmt_ext = uns ? $signed({1'b0, v}) : $signed({v[15], v});
  endfunction

  function automatic logic addr_valid(input tla_pkg::tla_addr_t a);
    case (a)
      tla_pkg::ADDR_CONFIG, tla_pkg::ADDR_ENH_CONFIG,
      tla_pkg::ADDR_FILTER_MODE, tla_pkg::ADDR_STATUS,
      tla_pkg::ADDR_LOCAL_TEMP, tla_pkg::ADDR_REMOTE_TEMP,
      tla_pkg::ADDR_LOCAL_HIGH, tla_pkg::ADDR_REMOTE_HIGH,
      tla_pkg::ADDR_REMOTE_LOW, tla_pkg::ADDR_REMOTE_CRIT,
      tla_pkg::ADDR_CRIT_HYST, tla_pkg::ADDR_LUT_HYST,
      tla_pkg::ADDR_REMOTE_OFFSET: addr_valid = 1'b1;
      default: addr_valid = 1'b0;
    endcase
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st);
    merge8 = st[0] ? wd[7:0] : old;
  endfunction

  // apb handshake: one wait state, effects at the completing edge
  assign wr_done = psel & penable & pready & pwrite;
  assign rd_done = psel & penable & pready & ~pwrite;
  assign status_rd = rd_done & (paddr == tla_pkg::ADDR_STATUS);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pslverr <= 1'b0;
    else
      pslverr <= psel & penable & ~pready & ~addr_valid(paddr);
  end

  // read data captured one cycle ahead of completion
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= '0;
    else if (psel & penable & ~pready & ~pwrite)
    begin
      case (paddr)
        tla_pkg::ADDR_CONFIG: prdata <= {24'h0, config_reg};
        tla_pkg::ADDR_ENH_CONFIG: prdata <= {24'h0, enh_config_reg};
        tla_pkg::ADDR_FILTER_MODE: prdata <= {24'h0, filter_mode_reg};
        tla_pkg::ADDR_STATUS:
        begin
          prdata <= '0;
          prdata[tla_pkg::NUM_FLAGS-1:0] <= flag_reg;
          prdata[tla_pkg::ST_REMOTE_DIODE_FAULT_FLAG_BIT] <= diode_fault;
          prdata[tla_pkg::ST_BUSY_BIT] <= conv_busy;
        end
        tla_pkg::ADDR_LOCAL_TEMP: prdata <= {24'h0, local_temp_reading};
        tla_pkg::ADDR_REMOTE_TEMP: prdata <= {16'h0, remote_temp_reading};
        tla_pkg::ADDR_LOCAL_HIGH: prdata <= {24'h0, local_high_limit};
        tla_pkg::ADDR_REMOTE_HIGH: prdata <= {16'h0, remote_high_limit};
        tla_pkg::ADDR_REMOTE_LOW: prdata <= {16'h0, remote_low_limit};
        tla_pkg::ADDR_REMOTE_CRIT: prdata <= {16'h0, remote_critical_limit};
        tla_pkg::ADDR_CRIT_HYST: prdata <= {24'h0, crit_hyst_reg};
        tla_pkg::ADDR_LUT_HYST: prdata <= {24'h0, lut_hyst_reg};
        tla_pkg::ADDR_REMOTE_OFFSET: prdata <= {16'h0, remote_offset_reg};
        default: prdata <= '0;
      endcase
    end
  end

  // setpoint and hysteresis registers; lookup hysteresis only stored
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enh_config_reg <= tla_pkg::ENH_CONFIG_RST;
      filter_mode_reg <= tla_pkg::FILTER_MODE_RST;
      local_high_limit <= tla_pkg::LOCAL_HIGH_RST;
      remote_high_limit <= tla_pkg::REMOTE_HIGH_RST;
      remote_low_limit <= tla_pkg::REMOTE_LOW_RST;
      remote_critical_limit <= tla_pkg::REMOTE_CRIT_RST;
      crit_hyst_reg <= tla_pkg::CRIT_HYST_RST;
      lut_hyst_reg <= tla_pkg::LUT_HYST_RST;
      remote_offset_reg <= tla_pkg::REMOTE_OFFSET_RST;
    end
    else if (wr_done)
    begin
      case (paddr)
        tla_pkg::ADDR_ENH_CONFIG:
          enh_config_reg <= merge8(enh_config_reg, pwdata, pstrb);
        tla_pkg::ADDR_FILTER_MODE:
          filter_mode_reg <= merge8(filter_mode_reg, pwdata, pstrb);
        tla_pkg::ADDR_LOCAL_HIGH:
          local_high_limit <= merge8(local_high_limit, pwdata, pstrb);
        tla_pkg::ADDR_REMOTE_HIGH:
          remote_high_limit <= merge16(remote_high_limit, pwdata, pstrb);
        tla_pkg::ADDR_REMOTE_LOW:
          remote_low_limit <= merge16(remote_low_limit, pwdata, pstrb);
        tla_pkg::ADDR_REMOTE_CRIT:
          remote_critical_limit <= merge16(remote_critical_limit, pwdata,
                                           pstrb);
        tla_pkg::ADDR_CRIT_HYST:
          crit_hyst_reg <= merge8(crit_hyst_reg, pwdata, pstrb);
        tla_pkg::ADDR_LUT_HYST:
          lut_hyst_reg <= merge8(lut_hyst_reg, pwdata, pstrb);
        tla_pkg::ADDR_REMOTE_OFFSET:
          remote_offset_reg <= merge16(remote_offset_reg, pwdata, pstrb);
        default:
        begin
        end
      endcase
    end
  end

  // hardware mask set wins over a software write in the same cycle
  assign irq_mode = ~comp_mode;
  assign qual_any = |flag_reg;
  assign ara_hit = alert_response_query & ~alert_cfg & ~alert_n;
  assign hw_mask_set = (status_rd & irq_mode & qual_any) | ara_hit;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      config_reg <= tla_pkg::CONFIG_RST;
    else
    begin
      if (wr_done && paddr == tla_pkg::ADDR_CONFIG)
        config_reg <= merge8(config_reg, pwdata, pstrb);
      if (hw_mask_set)
        config_reg[tla_pkg::CFG_MASK_BIT] <= 1'b1;
    end
  end

  // remote reading after offset, clamp and resolution select
  tla_remote_path u_remote_path (
    .raw(conv.remote_t),
    .offset(remote_offset_reg),
    .unsigned_format_select(unsigned_format_select),
    .filter_en(filter_en),
    .reading(remote_new)
  );

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      local_temp_reading <= '0;
      remote_temp_reading <= '0;
    end
    else if (conv.done)
    begin
      local_temp_reading <= conv.local_t;
      remote_temp_reading <= remote_new;
    end
  end

  // limit tests on the fresh reading; crit in whole degrees
  logic signed [16:0] rt_fmt;
  logic signed [16:0] rt_sgn;
  logic signed [9:0] rt_deg;
  logic signed [16:0] crit_fmt;
  logic signed [9:0] crit_deg;
  logic signed [9:0] crit_clear;

  always_comb
  begin
    rt_fmt = fmt_ext(remote_new, unsigned_format_select);
    rt_sgn = fmt_ext(remote_new, 1'b0);
    rt_deg = {rt_fmt[16], rt_fmt[16:8]};
    crit_fmt = fmt_ext(remote_critical_limit, unsigned_format_select);
    crit_deg = {crit_fmt[16], crit_fmt[16:8]};
    crit_clear = crit_deg - $signed({2'b00, crit_hyst_reg});
    viol = '0;
    viol[tla_pkg::FLG_LHIGH] = $signed(conv.local_t) >
                               $signed(local_high_limit);
    viol[tla_pkg::FLG_RHIGH] = rt_fmt >
                               fmt_ext(remote_high_limit, unsigned_format_select);
    viol[tla_pkg::FLG_RLOW] = rt_sgn <
                              fmt_ext(remote_low_limit, 1'b0);
    viol[tla_pkg::FLG_RCRIT] = rt_deg > crit_deg;
    // hysteresis: hold active until at or below limit minus hysteresis
    if (rt_deg > crit_deg)
      crit_active_next = 1'b1;
    else if (rt_deg <= crit_clear)
      crit_active_next = 1'b0;
    else
      crit_active_next = crit_active_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      crit_active_reg <= 1'b0;
    else if (conv.done)
      crit_active_reg <= crit_active_next;
  end

  // live out-of-limit condition, feeds comparator mode
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cond_reg <= '0;
    else if (conv.done)
    begin
      cond_reg <= viol;
      cond_reg[tla_pkg::FLG_RCRIT] <= crit_active_next;
    end
  end

  // sticky flags: a conversion setting a flag wins over a status read
  genvar g;
  generate
    for (g = 0; g < tla_pkg::NUM_FLAGS; g = g + 1)
    begin : g_flag
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          flag_reg[g] <= 1'b0;
        else if (conv.done && viol[g])
          flag_reg[g] <= 1'b1;
        else if (status_rd)
          flag_reg[g] <= 1'b0;
      end
    end
  endgenerate

  // alert pulls low only with mask clear; busy and fault never count
  always_comb
  begin
    if (mask)
      alert_next = 1'b0;
    else if (comp_mode)
      alert_next = |cond_reg;
    else
      alert_next = qual_any & ~status_rd & ~ara_hit;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      alert_n <= 1'b1;
    else
      alert_n <= ~(alert_next & ~ara_hit);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ara_ack <= 1'b0;
    else
      ara_ack <= ara_hit;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      critical_temp_out_n <= 1'b1;
    else
      critical_temp_out_n <= ~crit_active_reg;
  end

  // standby stops conversions; pwm optionally halted with it
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      conv_enable <= 1'b0;
      pwm_halt <= 1'b0;
    end
    else
    begin
      conv_enable <= ~config_reg[tla_pkg::CFG_STBY_BIT];
      pwm_halt <= config_reg[tla_pkg::CFG_STBY_BIT] &
                  config_reg[tla_pkg::CFG_PWMDIS_BIT];
    end
  end

endmodule
`default_nettype wire

/* common/tla_pkg.sv */
// constants, register map and carriers for the temperature limit alert logic
package tla_pkg;

  typedef logic [7:0] tla_addr_t;

  // apb byte addresses, one aligned word per register
  localparam tla_addr_t ADDR_CONFIG = 8'h00;
  localparam tla_addr_t ADDR_ENH_CONFIG = 8'h04;
  localparam tla_addr_t ADDR_FILTER_MODE = 8'h08;
  localparam tla_addr_t ADDR_STATUS = 8'h0c;
  localparam tla_addr_t ADDR_LOCAL_TEMP = 8'h10;
  localparam tla_addr_t ADDR_REMOTE_TEMP = 8'h14;
  localparam tla_addr_t ADDR_LOCAL_HIGH = 8'h18;
  localparam tla_addr_t ADDR_REMOTE_HIGH = 8'h1c;
  localparam tla_addr_t ADDR_REMOTE_LOW = 8'h20;
  localparam tla_addr_t ADDR_REMOTE_CRIT = 8'h24;
  localparam tla_addr_t ADDR_CRIT_HYST = 8'h28;
  localparam tla_addr_t ADDR_LUT_HYST = 8'h2c;
  localparam tla_addr_t ADDR_REMOTE_OFFSET = 8'h30;

  // configuration register fields
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_STBY_BIT = 6;
  localparam int CFG_PWMDIS_BIT = 5;
  // enhanced configuration
  localparam int ENH_USF_BIT = 3;
  // filter and comparator mode register
  localparam int FM_COMP_BIT = 0;
  localparam int FM_ALERTCFG_BIT = 1;
  localparam int FM_FILTER_BIT = 2;

  // qualifying limit flags, also their status bit positions
  localparam int NUM_FLAGS = 4;
  localparam int FLG_LHIGH = 0;
  localparam int FLG_RHIGH = 1;
  localparam int FLG_RLOW = 2;
  localparam int FLG_RCRIT = 3;
  localparam int ST_REMOTE_DIODE_FAULT_FLAG_BIT = 4;
  localparam int ST_BUSY_BIT = 7;

  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] ENH_CONFIG_RST = 8'h00;
  localparam logic [7:0] FILTER_MODE_RST = 8'h00;
  localparam logic [7:0] LOCAL_HIGH_RST = 8'h46;
  localparam logic [15:0] REMOTE_HIGH_RST = 16'h5500;
  localparam logic [15:0] REMOTE_LOW_RST = 16'h0000;
  localparam logic [15:0] REMOTE_CRIT_RST = 16'h6e00;
  localparam logic [7:0] CRIT_HYST_RST = 8'h0a;
  localparam logic [7:0] LUT_HYST_RST = 8'h0a;
  localparam logic [15:0] REMOTE_OFFSET_RST = 16'h0000;

  // reading resolution and clamps
  localparam logic [15:0] RES11_MASK = 16'hffe0;
  localparam logic [15:0] RES13_MASK = 16'hfff8;
  localparam logic signed [17:0] UNS_MAX = 18'sh0ffff;
  localparam logic signed [17:0] SGN_MAX = 18'sh07fff;
  localparam logic signed [17:0] SGN_MIN = -18'sh08000;
  localparam logic [15:0] UNS_MAX_W = 16'hffff;
  localparam logic [15:0] SGN_MAX_W = 16'h7fff;
  localparam logic [15:0] SGN_MIN_W = 16'h8000;
  localparam logic [15:0] ZERO_W = 16'h0000;

  // result of one conversion, same clock domain
  typedef struct packed {
    logic done;
    logic [7:0] local_t;
    logic [15:0] remote_t;
  } tla_conv_s;

endpackage

/* core/tla_remote_path.sv */
// remote reading path: offset add, clamp and resolution select
`timescale 1ns/1ns
`default_nettype none
module tla_remote_path (
  input wire logic [15:0] raw,
  input wire logic [15:0] offset,
  input wire logic unsigned_format_select,
  input wire logic filter_en,
  output logic [15:0] reading
);

  logic signed [17:0] ext_raw;
  logic signed [17:0] ext_off;
  logic signed [17:0] sum;
  logic [15:0] clamped;

  always_comb
  begin
    ext_raw = unsigned_format_select ? $signed({2'b00, raw}) : $signed({{2{raw[15]}}, raw});
    ext_off = $signed({{2{offset[15]}}, offset});
    sum = ext_raw + ext_off;
    // clamp, never roll over past full scale
    if (unsigned_format_select)
    begin
      if (sum < 0)
        clamped = tla_pkg::ZERO_W;
      else if (sum > tla_pkg::UNS_MAX)
        clamped = tla_pkg::UNS_MAX_W;
      else
        clamped = sum[15:0];
    end
    else
    begin
      if (sum > tla_pkg::SGN_MAX)
        clamped = tla_pkg::SGN_MAX_W;
      else if (sum < tla_pkg::SGN_MIN)
        clamped = tla_pkg::SGN_MIN_W;
      else
        clamped = sum[15:0];
    end
    reading = clamped & (filter_en ? tla_pkg::RES13_MASK
                                   : tla_pkg::RES11_MASK);
  end

endmodule
`default_nettype wire

/* verification/tla_alert_monitor.sv */
// port-level assertions for the temperature limit alert logic
`timescale 1ns/1ns
`default_nettype none
module tla_alert_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire tla_pkg::tla_conv_s conv,
  input wire logic alert_response_query,
  input wire logic alert_n,
  input wire logic critical_temp_out_n,
  input wire logic conv_enable,
  input wire logic pwm_halt,
  input wire logic ara_ack
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  property p_one_wait;
    s_setup |=> s_wait ##1 pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_cause;
    pready |-> $past(psel) && $past(penable);
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  // alert can only drop after a conversion or a register write
  property p_alert_cause;
    $fell(alert_n) |-> $past(conv.done, 2) ||
      ($past(psel, 2) && $past(pwrite, 2));
  endproperty
  property p_crit_cause;
    $fell(critical_temp_out_n) |-> $past(conv.done, 2);
  endproperty
  property p_ack;
    ara_ack |-> alert_n && $past(alert_response_query) && !$past(alert_n);
  endproperty
  property p_ack_pulse;
    ara_ack |=> !ara_ack;
  endproperty
  property p_halt_stby;
    pwm_halt |-> !conv_enable;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("apb answer not after exactly one wait state");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without an access phase");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  a_alert_cause: assert property (p_alert_cause)
    else $error("alert asserted without a cause");
  a_crit_cause: assert property (p_crit_cause)
    else $error("critical output asserted without a conversion");
  a_ack: assert property (p_ack)
    else $error("query answer without a pending alert");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("query answer longer than one cycle");
  a_halt_stby: assert property (p_halt_stby)
    else $error("pwm halted outside standby");
endmodule
bind tla_alert_top tla_alert_monitor mon_u (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .conv(conv),
  .alert_response_query(alert_response_query), .alert_n(alert_n),
  .critical_temp_out_n(critical_temp_out_n), .conv_enable(conv_enable),
  .pwm_halt(pwm_halt), .ara_ack(ara_ack)
);
`default_nettype wire

/* verification/tla_conv_model.sv */
// conversion source model: one-cycle result pulses and live status levels
`timescale 1ns/1ns
`default_nettype none
module tla_conv_model (
  input wire logic core_clk,
  output var tla_pkg::tla_conv_s conv,
  output logic conv_busy,
  output logic diode_fault
);
  initial
  begin
    conv = '0;
    conv_busy = 1'b0;
    diode_fault = 1'b0;
  end
  // data is only valid with done, so it is scrambled afterwards
  task automatic convert(input logic [7:0] lt, input logic [15:0] rt);
    @(posedge core_clk);
    conv <= {1'b1, lt, rt};
    @(posedge core_clk);
    conv <= {1'b0, ~lt, ~rt};
  endtask
  task automatic levels(input logic b, input logic f);
    @(posedge core_clk);
    conv_busy <= b;
    diode_fault <= f;
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// register-level tests of the temperature limit alert logic
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk, rst_b, psel, penable, pwrite, alert_response_query;
  tla_pkg::tla_addr_t paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, alert_n, critical_temp_out_n, err;
  logic conv_enable, pwm_halt, ara_ack, conv_busy, diode_fault;
  tla_pkg::tla_conv_s conv;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  tla_pkg::tla_addr_t ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
    8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
  logic [15:0] rv [13] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h46, 16'h5500, 16'h0, 16'h6e00, 16'h0a, 16'h0a, 16'h0};
  tla_alert_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv(conv), .conv_busy(conv_busy), .diode_fault(diode_fault),
    .alert_response_query(alert_response_query), .alert_n(alert_n),
    .critical_temp_out_n(critical_temp_out_n), .conv_enable(conv_enable),
    .pwm_halt(pwm_halt), .ara_ack(ara_ack));
  tla_conv_model conv_m (.core_clk(core_clk), .conv(conv),
    .conv_busy(conv_busy), .diode_fault(diode_fault));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      results();
    end
  end
  task results;
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // request held until pready is seen at a rising edge
  task apb(input logic w, input tla_pkg::tla_addr_t a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait count assumed: only the bench timeout ends a hung access
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input tla_pkg::tla_addr_t a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask
  task rchk(input tla_pkg::tla_addr_t a, input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(rd, {16'h0, e});
  endtask
  task cv(input logic [7:0] l, input logic [15:0] r);
    conv_m.convert(l, r);
    tick(3);
  endtask
  task query(input logic e);
    @(posedge core_clk);
    alert_response_query <= 1'b1;
    @(posedge core_clk);
    alert_response_query <= 1'b0;
    // answer launches at the edge that takes the query pulse
    tick(1);
    chk_bit(ara_ack, e);
    chk_bit(alert_n, e);
    tick(1);
    chk_bit(ara_ack, 1'b0);
  endtask
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h3;
    alert_response_query = 1'b0;
    tick(12);
    rst_b <= 1'b1;
    tick(2);
    chk_bit(conv_enable, 1'b1);
    for (int i = 0; i < 13; i++)
      rchk(ra[i], rv[i]);
    rchk(8'h40, 16'h0);
    chk_bit(err, 1'b1);
    wr(8'h28, 16'h05);
    rchk(8'h2c, 16'h0a);
    rchk(8'h28, 16'h05);
    cv(8'h10, 16'h5600);
    chk_bit(alert_n, 1'b0);
    rchk(8'h0c, 16'h02);
    tick(2);
    chk_bit(alert_n, 1'b1);
    rchk(8'h00, 16'h80);
    rchk(8'h0c, 16'h0);
    cv(8'h10, 16'h5600);
    chk_bit(alert_n, 1'b1);
    wr(8'h00, 16'h0);
    tick(3);
    chk_bit(alert_n, 1'b0);
    query(1'b1);
    rchk(8'h00, 16'h80);
    rchk(8'h0c, 16'h02);
    wr(8'h00, 16'h0);
    // alert config high: the query must be ignored
    wr(8'h08, 16'h02);
    cv(8'h10, 16'h5600);
    query(1'b0);
    rchk(8'h0c, 16'h02);
    wr(8'h08, 16'h0);
    wr(8'h00, 16'h0);
    wr(8'h08, 16'h01);
    cv(8'h10, 16'h5600);
    chk_bit(alert_n, 1'b0);
    cv(8'h10, 16'h5000);
    chk_bit(alert_n, 1'b1);
    rchk(8'h0c, 16'h02);
    rchk(8'h00, 16'h0);
    wr(8'h08, 16'h0);
    cv(8'h46, 16'h5500);
    rchk(8'h0c, 16'h0);
    cv(8'h47, 16'hff00);
    rchk(8'h0c, 16'h05);
    wr(8'h00, 16'h0);
    cv(8'h10, 16'h6e20);
    chk_bit(critical_temp_out_n, 1'b1);
    cv(8'h10, 16'h6f00);
    chk_bit(critical_temp_out_n, 1'b0);
    rchk(8'h0c, 16'h0a);
    cv(8'h10, 16'h6a00);
    chk_bit(critical_temp_out_n, 1'b0);
    cv(8'h10, 16'h6900);
    chk_bit(critical_temp_out_n, 1'b1);
    rchk(8'h0c, 16'h02);
    wr(8'h00, 16'h0);
    conv_m.levels(1'b1, 1'b1);
    tick(2);
    rchk(8'h0c, 16'h90);
    chk_bit(alert_n, 1'b1);
    rchk(8'h00, 16'h0);
    conv_m.levels(1'b0, 1'b0);
    wr(8'h30, 16'h0100);
    cv(8'h10, 16'h1908);
    rchk(8'h14, 16'h1a00);
    rchk(8'h10, 16'h10);
    wr(8'h08, 16'h04);
    cv(8'h10, 16'h1908);
    rchk(8'h14, 16'h1a08);
    wr(8'h08, 16'h0);
    wr(8'h30, 16'h0);
    cv(8'h10, 16'h9000);
    rchk(8'h0c, 16'h04);
    wr(8'h04, 16'h08);
    cv(8'h10, 16'h9000);
    rchk(8'h0c, 16'h0e);
    wr(8'h00, 16'h40);
    tick(2);
    chk_bit(conv_enable, 1'b0);
    chk_bit(pwm_halt, 1'b0);
    wr(8'h00, 16'h60);
    tick(2);
    chk_bit(pwm_halt, 1'b1);
    wr(8'h00, 16'h0);
    tick(2);
    chk_bit(conv_enable, 1'b1);
    results();
  end
endmodule
`default_nettype wire
